// ===== src/sce_top.sv
// error handling and recovery unit of a queue based storage controller
`timescale 1ns/10ps
// Notes on behaviour
// - deleting a queue aborts its outstanding commands
// - any queue deletion written outside a slot walk frees its resources
// - keep running; completion says if retry helps
// - media failure completes with media status
// - read error: stop transfer or deliver data
// - write error: abandon or finish transfer
// - small failed write keeps old data
// - large failed write may keep either
// - limited retry bit sets recovery effort
// - bus memory error halts until host
// - missing host address gives transfer error
// - internal error status, lowest code wins
// - serious fault sets the fatal flag
// - fatal flag raises no interrupt
// - subsystem reset may take links down
module sce_top
	import sce_pkg::*;
#(
	parameter int unsigned NSLOT       = 8,
	parameter int unsigned QID_W       = 4,
	parameter int unsigned AWUPF_BLKS  = 1,
	parameter int unsigned SIDX_W      = $clog2(NSLOT)
)
(
	// clock and reset
	input  wire logic              clk,
	input  wire logic              rst_n,
	// register port
	input  wire logic [7:0]        addr,
	input  wire logic [31:0]       wr_data,
	input  wire logic              wr_en,
	input  wire logic              rd_en,
	output logic      [31:0]       rd_data,
	// command issue
	input  wire logic              cmd_issue,
	input  wire logic [SIDX_W-1:0] issue_slot,
	input  wire logic [QID_W-1:0]  issue_sq,
	input  wire logic              issue_lr,
	output logic                   cmd_reject,
	// command end with its error flags
	input  wire logic              cmd_done,
	input  wire logic [SIDX_W-1:0] done_slot,
	input  wire logic              media_err,
	input  wire logic [7:0]        media_sc,
	input  wire logic              read_err,
	input  wire logic              write_err,
	input  wire logic [15:0]       write_blks,
	input  wire logic              bus_abort,
	input  wire logic              parity_err,
	input  wire logic              internal_err,
	// completion entry out
	output logic                   cpl_valid,
	output logic      [SIDX_W-1:0] cpl_slot,
	output logic      [SC_W-1:0]   cpl_status,
	output logic                   cpl_retry,
	output logic                   xfer_stop,
	output logic                   wr_commit_valid,
	output logic                   wr_commit,
	// recovery effort query
	input  wire logic              recov_req,
	input  wire logic [SIDX_W-1:0] recov_slot,
	output logic                   recov_valid,
	output logic                   recov_full,
	// fatal condition and subsystem reset
	input  wire logic              fatal_condition,
	input  wire logic              whole_subsystem_reset,
	output logic                   fatal_status_flag,
	output logic                   link_down
);

	localparam int unsigned NQ = 1 << QID_W;

	typedef struct packed {
		logic [NSLOT-1:0]            sv;
		logic [NSLOT-1:0][QID_W-1:0] sq;
		logic [NSLOT-1:0]            lr;
		logic [NQ-1:0]               sq_alloc;
		logic [NQ-1:0]               cq_alloc;
		logic                        rd_deliver;
		logic                        wr_finish;
		logic                        big_commit;
		logic                        fatal;
		logic                        halted;
		logic                        del_done;
		sce_del_t                    st;
		logic [SIDX_W-1:0]           idx;
		logic [QID_W-1:0]            del_q;
		logic                        cpl_valid;
		logic [SIDX_W-1:0]           cpl_slot;
		logic [SC_W-1:0]             cpl_status;
		logic                        cpl_retry;
		logic                        xfer_stop;
		logic                        wr_commit_valid;
		logic                        wr_commit;
		logic                        recov_valid;
		logic                        recov_full;
		logic                        cmd_reject;
		logic [LD_W-1:0]             ld_cnt;
		logic                        link_down;
		logic [31:0]                 rdata;
	} sce_state_t;

	sce_state_t s_r;
	sce_state_t s_nxt;

	logic             any_rst;
	logic             bus_err;
	logic [NSLOT-1:0] del_hit;

	sce_sel_if sel_if ();

	////////////////////////////////////////////////////////////////////////////////
	// status selection for the ending command
	assign bus_err             = bus_abort || parity_err;
	assign sel_if.media_err    = media_err || read_err || write_err;
	assign sel_if.media_sc     = media_sc;
	assign sel_if.xfer_err     = bus_abort;
	assign sel_if.internal_err = internal_err;
	// a command ending on a queue under deletion is aborted
	assign sel_if.sq_abort     = (s_r.st == SCE_SCAN) && (s_r.sq[done_slot] == s_r.del_q);

	sce_status_sel u_sel (
		.sel (sel_if.sel)
	);

	////////////////////////////////////////////////////////////////////////////////
	// per slot match against the queue being deleted
	genvar gi;
	generate
		for (gi = 0; gi < NSLOT; gi++)
		begin : g_hit
			assign del_hit[gi] = s_r.sv[gi] && (s_r.sq[gi] == s_r.del_q);
		end
	endgenerate

	// controller reset by software or whole subsystem reset
	assign any_rst = (wr_en && (addr == REG_CTRL) && wr_data[CTRL_RESET]) || whole_subsystem_reset;

	////////////////////////////////////////////////////////////////////////////////
	// next state
	always_comb
	begin
		s_nxt = s_r;
		s_nxt.cpl_valid = 1'b0;
		s_nxt.xfer_stop = 1'b0;
		s_nxt.wr_commit_valid = 1'b0;
		s_nxt.recov_valid = 1'b0;
		s_nxt.cmd_reject = 1'b0;
		s_nxt.rdata = 32'h0000_0000;

		// link down window after subsystem reset
		if (whole_subsystem_reset)
			s_nxt.ld_cnt = LD_W'(LINK_DOWN_CYC);
		else if (s_r.ld_cnt != '0)
			s_nxt.ld_cnt = s_r.ld_cnt - 1'b1;
		s_nxt.link_down = (s_nxt.ld_cnt != '0);

		// controller or subsystem reset overrides writes, commands and the deletion walk in that cycle
		if (any_rst)
		begin
			// reset frees every queue and slot
			s_nxt.sv = '0;
			s_nxt.lr = '0;
			s_nxt.sq_alloc = '0;
			s_nxt.cq_alloc = '0;
			s_nxt.rd_deliver = RST_RD_DELIVER;
			s_nxt.wr_finish = RST_WR_FINISH;
			s_nxt.big_commit = RST_BIG_COMMIT;
			s_nxt.halted = 1'b0;
			s_nxt.del_done = 1'b0;
			s_nxt.st = SCE_IDLE;
			s_nxt.idx = '0;
			s_nxt.fatal = 1'b0;
		end
		else
		begin
			// register writes
			if (wr_en)
			begin
				if (addr == REG_CTRL)
				begin
					s_nxt.rd_deliver = wr_data[CTRL_RD_DELIVER];
					s_nxt.wr_finish = wr_data[CTRL_WR_FINISH];
					s_nxt.big_commit = wr_data[CTRL_BIG_COMMIT];
					if (wr_data[CTRL_HALT_CLR])
						s_nxt.halted = 1'b0;
				end
				else if (addr == REG_QCREATE)
				begin
					if (wr_data[Q_IS_CQ])
						s_nxt.cq_alloc[wr_data[QID_W-1:0]] = 1'b1;
					else
						s_nxt.sq_alloc[wr_data[QID_W-1:0]] = 1'b1;
				end
				else if ((addr == REG_QDEL) && (s_r.st == SCE_IDLE))
				begin
					// completion queue frees at once, submission queue walks its slots
					if (wr_data[Q_IS_CQ])
					begin
						s_nxt.cq_alloc[wr_data[QID_W-1:0]] = 1'b0;
						s_nxt.del_done = 1'b1;
					end
					else
					begin
						s_nxt.sq_alloc[wr_data[QID_W-1:0]] = 1'b0;
						s_nxt.del_q = wr_data[QID_W-1:0];
						s_nxt.idx = '0;
						s_nxt.del_done = 1'b0;
						s_nxt.st = SCE_SCAN;
					end
				end
			end

			// a command ends: completion entry, transfer and commit decisions
			if (cmd_done && s_r.sv[done_slot])
			begin
				s_nxt.sv[done_slot] = 1'b0;
				s_nxt.cpl_valid = !s_r.fatal;
				s_nxt.cpl_slot = done_slot;
				s_nxt.cpl_status = sel_if.code;
				s_nxt.cpl_retry = sel_if.retry_ok;
				s_nxt.xfer_stop = (read_err && !s_r.rd_deliver) || (write_err && !s_r.wr_finish) || bus_err;
				// failed write: keep old blocks or let new data stand
				if (write_err)
				begin
					s_nxt.wr_commit_valid = 1'b1;
					if (32'(write_blks) <= AWUPF_BLKS)
						s_nxt.wr_commit = 1'b0;
					else
						s_nxt.wr_commit = s_r.big_commit;
				end
				// bus memory fault stops issue until software clears it
				if (bus_err)
					s_nxt.halted = 1'b1;
			end
			else if (s_r.st == SCE_SCAN)
			begin
				// walk slots, one abort completion per cycle
				if (del_hit[s_r.idx])
				begin
					s_nxt.sv[s_r.idx] = 1'b0;
					s_nxt.cpl_valid = !s_r.fatal;
					s_nxt.cpl_slot = s_r.idx;
					s_nxt.cpl_status = ST_ABORT_SQDEL;
					s_nxt.cpl_retry = 1'b0;
				end
				// last slot ends the walk and flags the deletion done
				if (32'(s_r.idx) == NSLOT - 1)
				begin
					s_nxt.st = SCE_IDLE;
					s_nxt.del_done = 1'b1;
					s_nxt.idx = '0;
				end
				else
					s_nxt.idx = s_r.idx + 1'b1;
			end

			// new command into a free slot of a live queue
			if (cmd_issue)
			begin
				if (s_nxt.sv[issue_slot] || !s_nxt.sq_alloc[issue_sq] || s_r.halted || s_r.fatal)
					s_nxt.cmd_reject = 1'b1;
				else
				begin
					s_nxt.sv[issue_slot] = 1'b1;
					s_nxt.sq[issue_slot] = issue_sq;
					s_nxt.lr[issue_slot] = issue_lr;
				end
			end

			// recovery effort follows the limited retry bit
			if (recov_req)
			begin
				s_nxt.recov_valid = 1'b1;
				s_nxt.recov_full = !s_r.lr[recov_slot];
			end
		end

		// fault is sticky and wins over a reset in the same cycle, no interrupt
		if (fatal_condition)
			s_nxt.fatal = 1'b1;

		// register reads, data stand one cycle
		if (rd_en)
		begin
			if (addr == REG_CTRL)
				s_nxt.rdata = {29'h0000_0000, s_r.big_commit, s_r.wr_finish, s_r.rd_deliver};
			else if (addr == REG_STATUS)
				s_nxt.rdata = {28'h000_0000, s_r.del_done, (s_r.st == SCE_SCAN), s_r.halted, s_r.fatal};
			else if (addr == REG_SQ_MAP)
				s_nxt.rdata = 32'(s_r.sq_alloc);
			else if (addr == REG_CQ_MAP)
				s_nxt.rdata = 32'(s_r.cq_alloc);
			else if (addr == REG_SLOTS)
				s_nxt.rdata = 32'(s_r.sv);
			// unmapped addresses read as zero
			else
				s_nxt.rdata = 32'h0000_0000;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s_r <= '0;
			// config bits to their reset values
			s_r.rd_deliver <= RST_RD_DELIVER;
			s_r.wr_finish <= RST_WR_FINISH;
			s_r.big_commit <= RST_BIG_COMMIT;
			s_r.st <= SCE_IDLE;
		end
		else
			s_r <= s_nxt;
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs straight from the state register
	assign rd_data           = s_r.rdata;
	assign cmd_reject        = s_r.cmd_reject;
	assign cpl_valid         = s_r.cpl_valid;
	assign cpl_slot          = s_r.cpl_slot;
	assign cpl_status        = s_r.cpl_status;
	assign cpl_retry         = s_r.cpl_retry;
	assign xfer_stop         = s_r.xfer_stop;
	assign wr_commit_valid   = s_r.wr_commit_valid;
	assign wr_commit         = s_r.wr_commit;
	assign recov_valid       = s_r.recov_valid;
	assign recov_full        = s_r.recov_full;
	assign fatal_status_flag = s_r.fatal;
	assign link_down         = s_r.link_down;

endmodule

// ===== src/sce_pkg.sv
// shared constants and types of the storage controller error unit
package sce_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// register byte offsets
	localparam logic [7:0] REG_CTRL    = 8'h00;
	localparam logic [7:0] REG_STATUS  = 8'h04;
	localparam logic [7:0] REG_QDEL    = 8'h08;
	localparam logic [7:0] REG_QCREATE = 8'h0C;
	localparam logic [7:0] REG_SQ_MAP  = 8'h10;
	localparam logic [7:0] REG_CQ_MAP  = 8'h14;
	localparam logic [7:0] REG_SLOTS   = 8'h18;

	////////////////////////////////////////////////////////////////////////////////
	// field positions
	localparam int unsigned CTRL_RD_DELIVER = 0;
	localparam int unsigned CTRL_WR_FINISH  = 1;
	localparam int unsigned CTRL_BIG_COMMIT = 2;
	localparam int unsigned CTRL_RESET      = 3;
	localparam int unsigned CTRL_HALT_CLR   = 4;
	localparam int unsigned STAT_FATAL      = 0;
	localparam int unsigned STAT_HALTED     = 1;
	localparam int unsigned STAT_DEL_BUSY   = 2;
	localparam int unsigned STAT_DEL_DONE   = 3;
	localparam int unsigned Q_IS_CQ         = 8;

	////////////////////////////////////////////////////////////////////////////////
	// values after reset
	localparam logic RST_RD_DELIVER = 1'b0;
	localparam logic RST_WR_FINISH  = 1'b0;
	localparam logic RST_BIG_COMMIT = 1'b0;

	////////////////////////////////////////////////////////////////////////////////
	// completion status codes: type in the top three bits, code below
	localparam int unsigned SC_W           = 11;
	localparam logic [10:0] ST_SUCCESS     = 11'h000;
	localparam logic [10:0] ST_DATA_XFER   = 11'h004;
	localparam logic [10:0] ST_INTERNAL    = 11'h006;
	localparam logic [10:0] ST_ABORT_SQDEL = 11'h008;
	localparam logic [10:0] ST_NONE        = 11'h7FF;
	localparam logic [2:0]  SCT_MEDIA      = 3'h2;

	////////////////////////////////////////////////////////////////////////////////
	// link down time after a whole subsystem reset
	localparam int unsigned CLK_PERIOD_NS = 100;
	localparam int unsigned LINK_DOWN_NS  = 1000;
	localparam int unsigned LINK_DOWN_CYC = (LINK_DOWN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned LD_W          = $clog2(LINK_DOWN_CYC + 1);

	////////////////////////////////////////////////////////////////////////////////
	// queue deletion walker states
	typedef enum logic [0:0] {
		SCE_IDLE,
		SCE_SCAN
	} sce_del_t;

endpackage

// ===== src/sce_sel_if.sv
// error flags to status selector and chosen code back
`timescale 1ns/10ps
interface sce_sel_if;
	import sce_pkg::*;
	logic            media_err;
	logic [7:0]      media_sc;
	logic            xfer_err;
	logic            internal_err;
	logic            sq_abort;
	logic [SC_W-1:0] code;
	logic            retry_ok;

	modport req (output media_err, media_sc, xfer_err, internal_err, sq_abort, input code, retry_ok);
	modport sel (input media_err, media_sc, xfer_err, internal_err, sq_abort, output code, retry_ok);
endinterface

// ===== src/sce_status_sel.sv
// picks the lowest valued status among active error conditions
`timescale 1ns/10ps
module sce_status_sel
	import sce_pkg::*;
(
	// error flags in, code out
	sce_sel_if.sel sel
);

	logic [SC_W-1:0] media_code;
	logic [SC_W-1:0] best;

	// lowest numerical code wins
	always_comb
	begin
		media_code = {SCT_MEDIA, sel.media_sc};
		best = ST_NONE;
		if (sel.sq_abort && (ST_ABORT_SQDEL < best))
			best = ST_ABORT_SQDEL;
		if (sel.xfer_err && (ST_DATA_XFER < best))
			best = ST_DATA_XFER;
		if (sel.internal_err && (ST_INTERNAL < best))
			best = ST_INTERNAL;
		if (sel.media_err && (media_code < best))
			best = media_code;
		if (best == ST_NONE)
			best = ST_SUCCESS;
		sel.code = best;
		// only a pure media failure may succeed on retry
		sel.retry_ok = sel.media_err && !sel.xfer_err && !sel.internal_err && !sel.sq_abort;
	end

endmodule

// ===== tb/sce_top_sva.sv
// assertions on the ports of the error handling unit
`timescale 1ns/10ps
module sce_top_sva
	import sce_pkg::*;
#(
	parameter int unsigned AWUPF_BLKS = 1
)
(
	// clock, reset, register port
	input wire logic            clk,
	input wire logic            rst_n,
	input wire logic [7:0]      addr,
	input wire logic [31:0]     wr_data,
	input wire logic            wr_en,
	// command traffic
	input wire logic            cmd_issue,
	input wire logic            cmd_reject,
	input wire logic            cmd_done,
	input wire logic            media_err,
	input wire logic [7:0]      media_sc,
	input wire logic            read_err,
	input wire logic            write_err,
	input wire logic [15:0]     write_blks,
	input wire logic            bus_abort,
	input wire logic            parity_err,
	input wire logic            internal_err,
	input wire logic            cpl_valid,
	input wire logic [SC_W-1:0] cpl_status,
	input wire logic            cpl_retry,
	input wire logic            xfer_stop,
	input wire logic            wr_commit_valid,
	input wire logic            wr_commit,
	// fatal and subsystem reset
	input wire logic            fatal_condition,
	input wire logic            whole_subsystem_reset,
	input wire logic            fatal_status_flag,
	input wire logic            link_down
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	////////////////////////////////////////////////////////////////////////////////
	// fatal flag
	fatal_set_a: assert property (fatal_condition |=> fatal_status_flag)
		else $error("fatal flag not set");
	fatal_hold_a: assert property (fatal_status_flag && !whole_subsystem_reset
		&& !(wr_en && addr == REG_CTRL && wr_data[CTRL_RESET]) |=> fatal_status_flag) else $error("fatal flag lost");
	fatal_quiet_a: assert property (cmd_done && fatal_status_flag |=> !cpl_valid)
		else $error("completion while fatal");
	fatal_reject_a: assert property (cmd_issue && fatal_status_flag |=> cmd_reject)
		else $error("issue taken while fatal");

	////////////////////////////////////////////////////////////////////////////////
	// completion status, small failed write commit and link down span
	media_cpl_a: assert property (cpl_valid && $past(cmd_done && media_err && !read_err && !write_err
		&& !bus_abort && !parity_err && !internal_err) |-> cpl_status == {SCT_MEDIA, $past(media_sc)} && cpl_retry)
		else $error("media completion wrong");
	xfer_err_a: assert property (cpl_valid && $past(cmd_done && bus_abort && !internal_err)
		|-> cpl_status == ST_DATA_XFER && xfer_stop) else $error("abort completion wrong");
	internal_err_a: assert property (cpl_valid && $past(cmd_done && internal_err && !bus_abort)
		|-> cpl_status == ST_INTERNAL && !cpl_retry) else $error("internal completion wrong");
	small_write_a: assert property (wr_commit_valid && $past(write_blks) <= AWUPF_BLKS |-> !wr_commit)
		else $error("small failed write committed");
	link_down_a: assert property (whole_subsystem_reset |=> link_down [*8] ##1 link_down [*2] ##1 !link_down)
		else $error("link down span wrong");
endmodule

bind sce_top sce_top_sva #(.AWUPF_BLKS(AWUPF_BLKS)) u_sva (.clk, .rst_n, .addr, .wr_data, .wr_en, .cmd_issue,
	.cmd_reject, .cmd_done, .media_err, .media_sc, .read_err, .write_err, .write_blks, .bus_abort, .parity_err,
	.internal_err, .cpl_valid, .cpl_status, .cpl_retry, .xfer_stop, .wr_commit_valid, .wr_commit,
	.fatal_condition, .whole_subsystem_reset, .fatal_status_flag, .link_down);

// ===== tb/sce_host_model.sv
// host side model driving the register port of the error unit
`timescale 1ns/10ps
module sce_host_model
(
	// clock
	input  wire logic        clk,
	// register port
	output logic      [7:0]  addr,
	output logic      [31:0] wr_data,
	output logic             wr_en,
	output logic             rd_en,
	input  wire logic [31:0] rd_data
);
	// idle bus at time zero
	initial
	begin
		addr = 8'h00;
		wr_data = 32'h0;
		wr_en = 1'b0;
		rd_en = 1'b0;
	end

	// one cycle write, bus scrambled on release
	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
		addr <= ~a;
		wr_data <= ~d;
	endtask

	// one cycle read, data taken in the following cycle
	task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		addr <= ~a;
		@(negedge clk);
		d = rd_data;
	endtask
endmodule

// ===== tb/testbench.sv
// self checking bench of the error handling unit
`timescale 1ns/10ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin mismatches++; $display("Error %0t: got %h want %h", $time, a, b); end end
module testbench;
	import sce_pkg::*;
	logic clk, rst_n, cmd_issue, issue_lr, cmd_reject, cmd_done, media_err, read_err, write_err, bus_abort;
	logic parity_err, internal_err, cpl_valid, cpl_retry, xfer_stop, wr_commit_valid, wr_commit, recov_req;
	logic recov_valid, recov_full, fatal_condition, whole_subsystem_reset, fatal_status_flag, link_down;
	logic [2:0] issue_slot, done_slot, cpl_slot, recov_slot;
	logic [3:0] issue_sq;
	logic [7:0] addr, media_sc;
	logic [10:0] cpl_status;
	logic [15:0] write_blks;
	logic [31:0] wr_data, rd_data, rd;
	logic wr_en, rd_en;
	int mismatches, compares, n;
	// error cases: config, flags {media,read,write,abort,parity,internal}, blocks, status, {stop,commit valid,commit}
	logic [2:0] cc [6] = '{3'h0, 3'h0, 3'h1, 3'h0, 3'h6, 3'h0};
	logic [5:0] cf [6] = '{6'h20, 6'h10, 6'h10, 6'h08, 6'h08, 6'h21};
	logic [15:0] cb [6] = '{16'h0, 16'h0, 16'h0, 16'h1, 16'h2, 16'h0};
	logic [10:0] cs [6] = '{11'h281, 11'h281, 11'h281, 11'h281, 11'h281, 11'h006};
	logic [2:0] cx [6] = '{3'h0, 3'h4, 3'h0, 3'h6, 3'h3, 3'h0};

	sce_host_model host (.clk, .addr, .wr_data, .wr_en, .rd_en, .rd_data);
	sce_top dut (.clk, .rst_n, .addr, .wr_data, .wr_en, .rd_en, .rd_data, .cmd_issue, .issue_slot, .issue_sq,
		.issue_lr, .cmd_reject, .cmd_done, .done_slot, .media_err, .media_sc, .read_err, .write_err, .write_blks,
		.bus_abort, .parity_err, .internal_err, .cpl_valid, .cpl_slot, .cpl_status, .cpl_retry, .xfer_stop,
		.wr_commit_valid, .wr_commit, .recov_req, .recov_slot, .recov_valid, .recov_full, .fatal_condition,
		.whole_subsystem_reset, .fatal_status_flag, .link_down);

	////////////////////////////////////////////////////////////////////////////////
	// command side drivers, fatal and subsystem reset pulses, final report
	task automatic issue(input logic [2:0] s, input logic [3:0] q, input logic lr);
		@(posedge clk);
		{cmd_issue, issue_slot, issue_sq, issue_lr} <= {1'b1, s, q, lr};
		@(posedge clk);
		cmd_issue <= 1'b0;
		@(negedge clk);
	endtask
	task automatic done_cmd(input logic [2:0] s, input logic [5:0] f, input logic [15:0] b);
		@(posedge clk);
		{cmd_done, done_slot, write_blks} <= {1'b1, s, b};
		{media_err, read_err, write_err, bus_abort, parity_err, internal_err} <= f;
		@(posedge clk);
		cmd_done <= 1'b0;
		@(negedge clk);
	endtask
	task automatic recov(input logic [2:0] s);
		@(posedge clk);
		{recov_req, recov_slot} <= {1'b1, s};
		@(posedge clk);
		recov_req <= 1'b0;
		@(negedge clk);
	endtask
	task automatic pulse_in(input bit fat);
		@(posedge clk);
		if (fat) fatal_condition <= 1'b1; else whole_subsystem_reset <= 1'b1;
		@(posedge clk);
		{fatal_condition, whole_subsystem_reset} <= 2'b00;
		@(negedge clk);
	endtask
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// clock and watchdog
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial
	begin
		repeat (3000) @(posedge clk);
		mismatches++;
		report_and_stop;
	end

	////////////////////////////////////////////////////////////////////////////////
	// test sequence
	initial
	begin
		{rst_n, cmd_issue, issue_slot, issue_sq, issue_lr, cmd_done, done_slot, write_blks} = '0;
		{media_err, read_err, write_err, bus_abort, parity_err, internal_err, recov_req, recov_slot} = '0;
		{fatal_condition, whole_subsystem_reset, media_sc} = {2'b00, 8'h81};
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		host.reg_rd(REG_STATUS, rd);
		`CHK(rd, 32'h0)
		host.reg_rd(8'h20, rd);
		`CHK(rd, 32'h0)
		host.reg_wr(REG_QCREATE, 32'h1);
		issue(3'h0, 4'h1, 1'b0);
		issue(3'h2, 4'h1, 1'b1);
		recov(3'h2);
		`CHK({recov_valid, recov_full}, 2'b10)
		recov(3'h0);
		`CHK({recov_valid, recov_full}, 2'b11)
		$display("test setup done");
		for (int i = 0; i < 6; i++)
		begin
			host.reg_wr(REG_CTRL, {29'h0, cc[i]});
			host.reg_rd(REG_CTRL, rd);
			`CHK(rd, {29'h0, cc[i]})
			done_cmd(3'h0, cf[i], cb[i]);
			`CHK({cpl_valid, cpl_status}, {1'b1, cs[i]})
			`CHK({xfer_stop, wr_commit_valid}, cx[i][2:1])
			if (cx[i][1]) `CHK(wr_commit, cx[i][0])
			if (i == 0 || i == 5) `CHK(cpl_retry, i == 0)
			issue(3'h0, 4'h1, 1'b0);
			`CHK(cmd_reject, 1'b0)
		end
		$display("test errors done");
		for (int i = 0; i < 2; i++)
		begin
			done_cmd(3'h0, i == 0 ? 6'h04 : 6'h02, 16'h0);
			`CHK({cpl_status, xfer_stop}, {i == 0 ? ST_DATA_XFER : ST_SUCCESS, 1'b1})
			issue(3'h0, 4'h1, 1'b0);
			`CHK(cmd_reject, 1'b1)
			host.reg_wr(REG_CTRL, 32'h10);
			issue(3'h0, 4'h1, 1'b0);
			`CHK(cmd_reject, 1'b0)
		end
		$display("test halt done");
		host.reg_wr(REG_QCREATE, 32'h2);
		issue(3'h5, 4'h2, 1'b0);
		host.reg_wr(REG_QDEL, 32'h1);
		n = 0;
		repeat (12)
		begin
			@(negedge clk);
			if (cpl_valid === 1'b1)
			begin
				n++;
				`CHK({cpl_status, cpl_retry, cpl_slot}, {ST_ABORT_SQDEL, 1'b0, ((n == 1) ? 3'h0 : 3'h2)})
			end
		end
		`CHK(n, 2)
		host.reg_rd(REG_STATUS, rd);
		`CHK(rd[3:2], 2'b10)
		host.reg_rd(REG_SLOTS, rd);
		`CHK(rd, 32'h20)
		host.reg_rd(REG_SQ_MAP, rd);
		`CHK(rd[2:1], 2'b10)
		issue(3'h0, 4'h1, 1'b0);
		`CHK(cmd_reject, 1'b1)
		host.reg_wr(REG_QCREATE, 32'h103);
		host.reg_wr(REG_QDEL, 32'h103);
		host.reg_rd(REG_CQ_MAP, rd);
		`CHK(rd, 32'h0)
		$display("test delete done");
		pulse_in(1'b1);
		done_cmd(3'h5, 6'h00, 16'h0);
		`CHK({cpl_valid, fatal_status_flag}, 2'b01)
		host.reg_rd(REG_STATUS, rd);
		`CHK(rd[0], 1'b1)
		issue(3'h1, 4'h2, 1'b0);
		`CHK(cmd_reject, 1'b1)
		host.reg_wr(REG_CTRL, 32'h8);
		fatal_condition <= 1'b1;
		@(negedge clk);
		`CHK(fatal_status_flag, 1'b0)
		host.reg_wr(REG_CTRL, 32'h8);
		host.reg_rd(REG_STATUS, rd);
		`CHK(rd[0], 1'b1)
		@(posedge clk);
		fatal_condition <= 1'b0;
		pulse_in(1'b0);
		`CHK({link_down, fatal_status_flag}, 2'b10)
		repeat (10) @(negedge clk);
		`CHK(link_down, 1'b0)
		$display("test fatal done");
		report_and_stop;
	end
endmodule
